// *** fwsb_bank.sv ***
// fwsb_bank: flash control, irq flag/watchdog and interrupt input view sfrs
// assumes sfr bus on the mpu clock; flash engine and watchdog live outside
// Functional notes
// - program write enable steers movx to flash
// - write enable self-clears after each flash byte
// - write enable writes ignored while interrupts enabled
// - mass erase enable write-only, one-shot arming
// - secure bit blocks external flash reads
// - secure cleared only by reset, set-only
// - preboot status reads high while active
// - hardware sets transfer flag, handler clears
// - hardware sets rtc flag, handler clears
// - top bit reads pll-fall; zero clears
// - writing one restarts watchdog, flag kept
// - input view shows seven interrupt inputs
// - input view has no storage
// - mass erase needs enable, code, debug port
`timescale 1ns/10ps
`default_nettype none
module fwsb_bank (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // sfr bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output var  logic [7:0] sfr_rdata,
    // core status
    input  wire logic       global_irq_enable,
    input  wire logic       movx_store,
    input  wire logic       flash_byte_done,
    input  wire logic       debug_port_enable,
    input  wire logic       preboot_active,
    // events
    input  wire logic       transfer_busy_event,
    input  wire logic       rtc_second_event,
    input  wire logic       pll_fall_event,
    // pins
    input  wire logic [6:0] ext_irq_inputs,
    // flash and watchdog control
    output logic            program_write_enable,
    output logic            movx_to_flash,
    output logic            mass_erase_start,
    output logic            external_read_block,
    output logic            watchdog_restart,
    // interrupt requests
    output logic            transfer_irq_req,
    output logic            rtc_irq_req,
    output logic            pll_fall_irq_req
);
    logic                                 mass_erase_enable;
    logic                                 secure;
    logic                                 transfer_irq_flag;
    logic                                 rtc_irq_flag;
    logic                                 pll_fall_flag;
    logic [fwsb_pkg::EXT_IRQ_COUNT-1:0]   ext_irq_sync;
    logic                                 preboot_sync;
    logic [7:0]                           next_rdata;

    // pins and preboot status cross in via two flops
    fwsb_sync #(.WIDTH(fwsb_pkg::EXT_IRQ_COUNT + 1)) u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in ({preboot_active, ext_irq_inputs}),
        .sync_out ({preboot_sync, ext_irq_sync})
    );

    wire wr_flash = sfr_wr && (sfr_addr == fwsb_pkg::ADDR_FLASH_CONTROL);
    wire wr_flags = sfr_wr && (sfr_addr == fwsb_pkg::ADDR_IRQ_FLAGS_WDOG);
    wire wr_erase = sfr_wr && (sfr_addr == fwsb_pkg::ADDR_ERASE_COMMAND);
    wire pwe_wr_ok = wr_flash && !global_irq_enable;
    // write-zero-to-clear; set wins over clear in the same cycle
    wire clr_xfer = wr_flags && !sfr_wdata[fwsb_pkg::BIT_TRANSFER_FLAG];
    wire clr_rtc  = wr_flags && !sfr_wdata[fwsb_pkg::BIT_RTC_FLAG];
    wire clr_pll  = wr_flags && !sfr_wdata[fwsb_pkg::BIT_PLL_FALL];
    wire erase_ok = wr_erase && (sfr_wdata == fwsb_pkg::ERASE_MASS_CODE)
                    && mass_erase_enable && debug_port_enable;

    always_ff @(posedge clock) begin
        if (srst) begin
            program_write_enable <= fwsb_pkg::RESET_FLAG;
        end else if (flash_byte_done) begin
            program_write_enable <= 1'b0;
        end else if (pwe_wr_ok) begin
            program_write_enable <= sfr_wdata[fwsb_pkg::BIT_PROG_WRITE_EN];
        end
    end

    // arming is consumed by the next erase command write, whatever its code
    always_ff @(posedge clock) begin
        if (srst) begin
            mass_erase_enable <= fwsb_pkg::RESET_FLAG;
        end else if (wr_flash) begin
            mass_erase_enable <= sfr_wdata[fwsb_pkg::BIT_MASS_ERASE_EN];
        end else if (wr_erase) begin
            mass_erase_enable <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            secure <= fwsb_pkg::RESET_FLAG;
        end else if (wr_flash && sfr_wdata[fwsb_pkg::BIT_SECURE]) begin
            secure <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            transfer_irq_flag <= fwsb_pkg::RESET_FLAG;
            rtc_irq_flag      <= fwsb_pkg::RESET_FLAG;
            pll_fall_flag     <= fwsb_pkg::RESET_FLAG;
        end else begin
            transfer_irq_flag <= transfer_busy_event || (transfer_irq_flag && !clr_xfer);
            rtc_irq_flag      <= rtc_second_event || (rtc_irq_flag && !clr_rtc);
            pll_fall_flag     <= pll_fall_event || (pll_fall_flag && !clr_pll);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mass_erase_start <= 1'b0;
            watchdog_restart <= 1'b0;
            sfr_rdata        <= 8'h00;
        end else begin
            mass_erase_start <= erase_ok;
            watchdog_restart <= wr_flags && sfr_wdata[fwsb_pkg::BIT_PLL_FALL];
            sfr_rdata        <= next_rdata;
        end
    end

    // read data: whole-byte views; erase command reads as zero (write-only)
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_rd) begin
            unique case (sfr_addr)
                fwsb_pkg::ADDR_FLASH_CONTROL: begin
                    next_rdata[fwsb_pkg::BIT_PROG_WRITE_EN] = program_write_enable;
                    next_rdata[fwsb_pkg::BIT_SECURE]        = secure;
                    next_rdata[fwsb_pkg::BIT_PREBOOT]       = preboot_sync;
                end
                fwsb_pkg::ADDR_IRQ_FLAGS_WDOG: begin
                    next_rdata[fwsb_pkg::BIT_TRANSFER_FLAG] = transfer_irq_flag;
                    next_rdata[fwsb_pkg::BIT_RTC_FLAG]      = rtc_irq_flag;
                    next_rdata[fwsb_pkg::BIT_PLL_FALL]      = pll_fall_flag;
                end
                fwsb_pkg::ADDR_INTERRUPT_VIEW: begin
                    next_rdata = {1'b0, ext_irq_sync};
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // flash redirect of movx stores; core is expected to write full bytes
    assign movx_to_flash       = program_write_enable && movx_store;
    assign external_read_block = secure;
    assign transfer_irq_req    = transfer_irq_flag;
    assign rtc_irq_req         = rtc_irq_flag;
    assign pll_fall_irq_req    = pll_fall_flag;

    a_pwe_ignored: assert property (@(posedge clock) disable iff (srst)
        (wr_flash && global_irq_enable && !flash_byte_done) |=> $stable(program_write_enable))
        else $error("write enable changed while interrupts enabled");
    a_pwe_selfclear: assert property (@(posedge clock) disable iff (srst)
        flash_byte_done |=> !program_write_enable)
        else $error("write enable not cleared after flash byte");
    a_secure_sticky: assert property (@(posedge clock) disable iff (srst)
        secure |=> secure)
        else $error("secure bit cleared without reset");
    a_xfer_set: assert property (@(posedge clock) disable iff (srst)
        transfer_busy_event |=> transfer_irq_req)
        else $error("transfer flag not set on event");
    a_rtc_set: assert property (@(posedge clock) disable iff (srst)
        rtc_second_event |=> rtc_irq_req)
        else $error("rtc flag not set on event");
    a_pll_keep: assert property (@(posedge clock) disable iff (srst)
        (wr_flags && sfr_wdata[7] && pll_fall_flag) |=> (pll_fall_flag && watchdog_restart))
        else $error("watchdog restart disturbed pll flag");
    a_pll_clear: assert property (@(posedge clock) disable iff (srst)
        (wr_flags && !sfr_wdata[7] && !pll_fall_event) |=> !pll_fall_flag)
        else $error("pll flag not cleared by zero write");
    sequence s_arm;
        wr_flash && sfr_wdata[1];
    endsequence
    sequence s_erase;
        wr_erase && sfr_wdata == 8'hAA && debug_port_enable;
    endsequence
    a_erase_start: assert property (@(posedge clock) disable iff (srst)
        (s_arm ##1 (!wr_flash && !wr_erase) [*1] ##1 s_erase) |=> mass_erase_start)
        else $error("armed mass erase did not start");
    a_erase_guard: assert property (@(posedge clock) disable iff (srst)
        mass_erase_start |-> $past(mass_erase_enable) && $past(debug_port_enable))
        else $error("mass erase started without arming");
    a_view_live: assert property (@(posedge clock) disable iff (srst)
        (sfr_rd && sfr_addr == 8'hF8) |=> sfr_rdata == {1'b0, $past(ext_irq_sync)})
        else $error("input view mismatch");
    // a write that gets through must land, otherwise the ignore check proves nothing
    a_pwe_write: assert property (@(posedge clock) disable iff (srst)
        (pwe_wr_ok && !flash_byte_done) |=> program_write_enable == $past(sfr_wdata[fwsb_pkg::BIT_PROG_WRITE_EN]))
        else $error("allowed write enable write lost");
    a_xfer_clear: assert property (@(posedge clock) disable iff (srst)
        (clr_xfer && !transfer_busy_event) |=> !transfer_irq_flag)
        else $error("transfer flag not cleared by zero write");
    a_rtc_clear: assert property (@(posedge clock) disable iff (srst)
        (clr_rtc && !rtc_second_event) |=> !rtc_irq_flag)
        else $error("rtc flag not cleared by zero write");
    a_secure_set: assert property (@(posedge clock) disable iff (srst)
        (wr_flash && sfr_wdata[fwsb_pkg::BIT_SECURE]) |=> secure)
        else $error("secure bit not set by one write");
    a_erase_oneshot: assert property (@(posedge clock) disable iff (srst)
        wr_erase |=> !mass_erase_enable)
        else $error("mass erase arming survived a command write");
    a_restart_pulse: assert property (@(posedge clock) disable iff (srst)
        !(wr_flags && sfr_wdata[fwsb_pkg::BIT_PLL_FALL]) |=> !watchdog_restart)
        else $error("watchdog restart without a one write");
    a_preboot_read: assert property (@(posedge clock) disable iff (srst)
        (sfr_rd && sfr_addr == fwsb_pkg::ADDR_FLASH_CONTROL) |=> sfr_rdata[7] == $past(preboot_sync))
        else $error("preboot status read mismatch");
endmodule : fwsb_bank
`default_nettype wire

// *** fwsb_pkg.sv ***
// fwsb_pkg: offsets, bit positions and reset values of the flash/watchdog/irq sfr bank
// assumes an 8051-style sfr bus with 8-bit addresses and byte data
package fwsb_pkg;
    localparam logic [7:0] ADDR_FLASH_CONTROL    = 8'hB2;
    localparam logic [7:0] ADDR_IRQ_FLAGS_WDOG   = 8'hE8;
    localparam logic [7:0] ADDR_INTERRUPT_VIEW   = 8'hF8;
    localparam logic [7:0] ADDR_ERASE_COMMAND    = 8'h94;
    localparam logic [7:0] ERASE_MASS_CODE       = 8'hAA;
    localparam int         BIT_PROG_WRITE_EN     = 0;
    localparam int         BIT_MASS_ERASE_EN     = 1;
    localparam int         BIT_SECURE            = 6;
    localparam int         BIT_PREBOOT           = 7;
    localparam int         BIT_TRANSFER_FLAG     = 0;
    localparam int         BIT_RTC_FLAG          = 1;
    localparam int         BIT_PLL_FALL          = 7;
    localparam int         EXT_IRQ_COUNT         = 7;
    localparam logic       RESET_FLAG            = 1'b0;
endpackage : fwsb_pkg

// *** fwsb_sync.sv ***
// fwsb_sync: two-flop level synchroniser, one per bit
// assumes inputs asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
module fwsb_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // level in and out
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) $error("fwsb_sync: WIDTH must be positive");
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : fwsb_sync
`default_nettype wire

// *** tb.sv ***
// tb: self-checking bench for the flash/watchdog/irq sfr bank
// assumes fwsb_bank on one 250 MHz clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic       global_irq_enable = 1'b0;
    logic       movx_store = 1'b0;
    logic       flash_byte_done = 1'b0;
    logic       debug_port_enable = 1'b0;
    logic       preboot_active = 1'b0;
    logic       transfer_busy_event = 1'b0;
    logic       rtc_second_event = 1'b0;
    logic       pll_fall_event = 1'b0;
    logic [6:0] ext_irq_inputs = 7'h00;
    logic       program_write_enable, movx_to_flash, mass_erase_start, external_read_block;
    logic       watchdog_restart, transfer_irq_req, rtc_irq_req, pll_fall_irq_req;
    int         n_errors = 0;
    int         checks = 0;
    int         seed = 74;
    logic [7:0] rv, fl, msk;
    logic [3:0] erase_tab [4];
    always #2 clock = ~clock;
    fwsb_bank DUT (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .global_irq_enable(global_irq_enable),
        .movx_store(movx_store), .flash_byte_done(flash_byte_done), .debug_port_enable(debug_port_enable),
        .preboot_active(preboot_active), .transfer_busy_event(transfer_busy_event),
        .rtc_second_event(rtc_second_event), .pll_fall_event(pll_fall_event), .ext_irq_inputs(ext_irq_inputs),
        .program_write_enable(program_write_enable), .movx_to_flash(movx_to_flash),
        .mass_erase_start(mass_erase_start), .external_read_block(external_read_block),
        .watchdog_restart(watchdog_restart), .transfer_irq_req(transfer_irq_req), .rtc_irq_req(rtc_irq_req),
        .pll_fall_irq_req(pll_fall_irq_req));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // bus cycles end 1 ns past the taking edge, once its updates have landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfr_rd <= 1'b1; sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask : rd
    // bits that the flash control read is defined for: 7, 6, 1, 0
    function automatic logic [7:0] ctl_exp(input logic pre, input logic sec, input logic pwe);
        return {pre, sec, 5'h00, pwe};
    endfunction : ctl_exp
    function automatic logic [7:0] flags_now();
        return {pll_fall_irq_req, 5'h00, rtc_irq_req, transfer_irq_req};
    endfunction : flags_now
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
    initial begin
        // arm, debug, code is 0xAA, expected start
        erase_tab = '{4'b1111, 4'b0110, 4'b1100, 4'b1010};
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        #1 chk("reset outputs", {external_read_block, mass_erase_start, program_write_enable}, 8'h00);
        global_irq_enable <= 1'b1;
        wr(8'hB2, 8'h41);
        chk("pwe under ea", program_write_enable, 8'h00);
        chk("secure set", external_read_block, 8'h01);
        wr(8'hB2, 8'h00);
        chk("secure sticky", external_read_block, 8'h01);
        global_irq_enable <= 1'b0;
        wr(8'hB2, 8'h41);
        chk("pwe set", program_write_enable, 8'h01);
        movx_store <= 1'b1;
        #1 chk("movx to flash", movx_to_flash, 8'h01);
        @(posedge clock) flash_byte_done <= 1'b1;
        @(posedge clock) flash_byte_done <= 1'b0;
        #1 chk("pwe self clear", {movx_to_flash, program_write_enable}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            if (erase_tab[i][3]) wr(8'hB2, 8'h42);
            debug_port_enable <= erase_tab[i][2];
            wr(8'h94, erase_tab[i][1] ? 8'hAA : 8'h55);
            chk("erase start", mass_erase_start, erase_tab[i][0]);
            @(posedge clock);
            #1 chk("erase pulse end", mass_erase_start, 8'h00);
        end
        preboot_active <= 1'b1;
        repeat (3) @(posedge clock);
        // armed on purpose: the enable must still read back as zero
        wr(8'hB2, 8'h42);
        rd(8'hB2, rv);
        chk("flash control", rv & 8'hC3, ctl_exp(1'b1, 1'b1, 1'b0));
        @(posedge clock);
        transfer_busy_event <= 1'b1; rtc_second_event <= 1'b1; pll_fall_event <= 1'b1;
        @(posedge clock);
        transfer_busy_event <= 1'b0; rtc_second_event <= 1'b0; pll_fall_event <= 1'b0;
        #1 chk("irq requests", flags_now(), 8'h83);
        rd(8'hE8, rv);
        chk("flag read", rv & 8'h83, 8'h83);
        wr(8'hE8, 8'hFF);
        chk("restart pulse", watchdog_restart, 8'h01);
        chk("restart kept", flags_now(), 8'h83);
        fl = 8'h83;
        for (int i = 0; i < 3; i++) begin
            msk = (i == 2) ? 8'h7F : ~(8'h01 << i);
            fl = fl & msk;
            wr(8'hE8, msk);
            chk("flag clear", flags_now(), fl);
            chk("restart", watchdog_restart, msk[7]);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) ext_irq_inputs <= 7'($random(seed));
            repeat (3) @(posedge clock);
            rd(8'hF8, rv);
            chk("input view", rv, {1'b0, ext_irq_inputs});
        end
        // only a reset may drop the secure bit
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        #1 chk("mid-run reset", {external_read_block, pll_fall_irq_req, program_write_enable}, 8'h00);
        repeat (3) @(posedge clock);
        rd(8'hB2, rv);
        chk("secure after reset", rv & 8'hC3, ctl_exp(1'b1, 1'b0, 1'b0));
        conclude();
    end
endmodule : tb
`default_nettype wire
